// ===== hw/gsp_top.sv
// global strap, status pin and interrupt logic with bus slave
// What this block does
// RULE1: reset high returns everything to defaults
// RULE2: board holds reset two clocks minimum
// RULE3: release latches source-select pin into bit
// RULE4: enabled pin then picks input pair
// RULE5: rate strap sets rate family defaults
// RULE6: strap pin becomes general io four
// RULE7: enabled fail pin follows latched fail
// RULE8: disabled fail pin floats
// RULE9: enabled lock pin shows dpll lock
// RULE10: disabled lock pin driven low
// RULE11: mode bit picks interrupt or loss
// RULE12: interrupt pin polarity, drive, gpo options
// RULE13: loss mode shows live activity result
// RULE14: internal reset releases on the clock
`timescale 1ns/1ps
`default_nettype none
module gsp_top (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // device pins
    input wire logic fast_source_select_pin,
    input wire logic general_io_pin4_in,
    output logic general_io_pin4_out,
    output logic general_io_pin4_oe,
    output logic ref_fail_output,
    output logic ref_fail_output_oe,
    output logic lock_pin_out,
    output logic irq_request_out,
    output logic irq_request_out_oe,
    // from the core
    input wire logic ref_fail_in,
    input wire logic dpll_locked,
    input wire logic sel_ref_active,
    // to the core
    output logic pair_select,
    output logic rate_family_bit,
    output logic digital_out1_rate_sel,
    output logic digital_out2_rate_sel,
    output logic irq
);
    import gsp_pkg::*;

    logic rst_int; // clock-released reset
    logic fast_source_select_pin_lvl; // settled source-select pin
    logic io4_lvl; // settled io4 pin
    logic strap_done_q; // straps taken
    logic main_config_reg_one_q; // lock pin enable
    logic [2:0] rate_cfg_q; // rate family and output rates
    logic [1:0] main_config_reg_ten_q; // switch enable, fail pin
    logic [4:0] irq_config_reg_q; // shared pin setup
    logic [3:0] main_status_reg_two_q; // sticky events
    logic [3:0] irq_mask_q; // interrupt mask
    logic [1:0] general_io_control_reg_q; // io4 dir and value
    logic fail_prev_q; // edge history
    logic lock_prev_q;
    logic los_prev_q;
    logic io4_prev_q;
    logic wait_q; // waitrequest
    logic [31:0] rdata_q; // read data
    logic irq_q;
    logic pair_q;
    logic io4_out_q;
    logic io4_oe_q;
    logic srf_q;
    logic srf_oe_q;
    logic lock_q;
    logic intr_q;
    logic intr_oe_q;
    logic los_now; // loss of selected reference
    logic wr_acc; // write taken this edge
    logic wr_lo; // byte lane zero written
    logic [3:0] ev_set; // events this cycle
    logic [3:0] ev_clr; // software clears
    logic [31:0] rd_mux;
    logic intr_val; // interrupt pin level

    // release reset on the clock so all defaults leave together
    gsp_rst_sync u_rst ( // RULE14
        .core_clk(core_clk),
        .rst(rst),
        .rst_out(rst_int)
    );

    // pins from outside the clock domain
    gsp_sync3 u_fast_source_select_pin (
        .core_clk(core_clk),
        .pin_in(fast_source_select_pin),
        .level_out(fast_source_select_pin_lvl)
    );
    gsp_sync3 u_io4 (
        .core_clk(core_clk),
        .pin_in(general_io_pin4_in),
        .level_out(io4_lvl)
    );

    assign los_now = ~sel_ref_active;
    assign wr_acc = avs_write && !wait_q;
    assign wr_lo = wr_acc && avs_byteenable[0];

    // strap capture flag; first edge after internal release
    always_ff @(posedge core_clk or posedge rst_int) begin
        if (rst_int) begin
            strap_done_q <= 1'b0; // RULE1
        end else begin
            strap_done_q <= 1'b1;
        end
    end

    // bus handshake: one wait cycle, then one ready cycle
    always_ff @(posedge core_clk or posedge rst_int) begin
        if (rst_int) begin
            wait_q <= 1'b1;
        end else if (wait_q && (avs_read || avs_write)) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end

    // read mux; unmapped words read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (avs_address == GSP_CFG1_OFS) begin
            rd_mux[0] = main_config_reg_one_q;
        end else if (avs_address == GSP_RATE_OFS) begin
            rd_mux[2:0] = rate_cfg_q;
        end else if (avs_address == GSP_CFG10_OFS) begin
            rd_mux[1:0] = main_config_reg_ten_q;
        end else if (avs_address == GSP_IRQCFG_OFS) begin
            rd_mux[4:0] = irq_config_reg_q;
        end else if (avs_address == GSP_STS2_OFS) begin
            rd_mux[3:0] = main_status_reg_two_q;
        end else if (avs_address == GSP_MASK_OFS) begin
            rd_mux[3:0] = irq_mask_q;
        end else if (avs_address == GSP_IOCTL_OFS) begin
            rd_mux[1:0] = general_io_control_reg_q;
        end else if (avs_address == GSP_IOSTS_OFS) begin
            rd_mux[0] = io4_lvl; // RULE6
        end else if (avs_address == GSP_LIVE_OFS) begin
            rd_mux[GSP_LV_PAIR_BIT] = pair_q;
            rd_mux[GSP_LV_LOCK_BIT] = dpll_locked;
            rd_mux[GSP_LV_LOS_BIT] = los_now;
            rd_mux[GSP_LV_FAIL_BIT] = ref_fail_in;
        end
    end

    // read data caught in the wait cycle, stands on the ready edge
    always_ff @(posedge core_clk or posedge rst_int) begin
        if (rst_int) begin
            rdata_q <= 32'h0000_0000;
        end else if (wait_q && avs_read) begin
            rdata_q <= rd_mux;
        end
    end

    // config registers; straps load their defaults in the capture cycle
    // a bus write cannot land in that cycle, the bus is still waiting then
    always_ff @(posedge core_clk or posedge rst_int) begin
        if (rst_int) begin
            main_config_reg_one_q <= GSP_CFG1_RST;
            rate_cfg_q <= GSP_RATE_RST;
            main_config_reg_ten_q <= GSP_CFG10_RST;
            irq_config_reg_q <= GSP_IRQCFG_RST; // RULE11
            irq_mask_q <= GSP_MASK_RST;
            general_io_control_reg_q <= GSP_IOCTL_RST; // input, strap not fought
        end else if (!strap_done_q) begin
            rate_cfg_q <= {3{io4_lvl}}; // RULE5
            main_config_reg_ten_q[GSP_EXTSW_BIT] <= fast_source_select_pin_lvl; // RULE3
        end else if (wr_lo) begin
            if (avs_address == GSP_CFG1_OFS) begin
                main_config_reg_one_q <= avs_writedata[GSP_LOCK_EN_BIT];
            end else if (avs_address == GSP_RATE_OFS) begin
                rate_cfg_q <= avs_writedata[2:0];
            end else if (avs_address == GSP_CFG10_OFS) begin
                main_config_reg_ten_q <= avs_writedata[1:0];
            end else if (avs_address == GSP_IRQCFG_OFS) begin
                irq_config_reg_q <= avs_writedata[4:0];
            end else if (avs_address == GSP_MASK_OFS) begin
                irq_mask_q <= avs_writedata[3:0];
            end else if (avs_address == GSP_IOCTL_OFS) begin
                general_io_control_reg_q <= avs_writedata[1:0]; // RULE6
            end
        end
    end

    // edge history for event detection
    always_ff @(posedge core_clk or posedge rst_int) begin
        if (rst_int) begin
            fail_prev_q <= 1'b0;
            lock_prev_q <= 1'b0;
            los_prev_q <= 1'b0;
            io4_prev_q <= 1'b0;
        end else begin
            fail_prev_q <= ref_fail_in;
            lock_prev_q <= dpll_locked;
            los_prev_q <= los_now;
            io4_prev_q <= io4_lvl;
        end
    end

    // events held off for the capture cycle, history is stale then
    always_comb begin
        ev_set = 4'h0;
        ev_set[GSP_ST_FAIL_BIT] = ref_fail_in & ~fail_prev_q;
        ev_set[GSP_ST_LOCK_BIT] = dpll_locked ^ lock_prev_q;
        ev_set[GSP_ST_LOS_BIT] = los_now & ~los_prev_q;
        ev_set[GSP_ST_IO4_BIT] = io4_lvl ^ io4_prev_q;
        if (!strap_done_q) begin
            ev_set = 4'h0;
        end
    end

    // write one to clear
    assign ev_clr = (wr_lo && avs_address == GSP_STS2_OFS) ?
        avs_writedata[3:0] : 4'h0;

    // sticky status; a new event beats a clear in the same cycle
    always_ff @(posedge core_clk or posedge rst_int) begin
        if (rst_int) begin
            main_status_reg_two_q <= GSP_STS_RST;
        end else begin
            main_status_reg_two_q <= (main_status_reg_two_q & ~ev_clr) | ev_set;
        end
    end

    // level interrupt from unmasked sticky bits
    always_ff @(posedge core_clk or posedge rst_int) begin
        if (rst_int) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(main_status_reg_two_q & irq_mask_q);
        end
    end

    // pin drivers, each one flop behind its control
    always_ff @(posedge core_clk or posedge rst_int) begin
        if (rst_int) begin
            pair_q <= 1'b0;
            io4_oe_q <= 1'b0;
            io4_out_q <= 1'b0;
            srf_q <= 1'b0;
            srf_oe_q <= 1'b0;
            lock_q <= 1'b0;
        end else begin
            // pair follows the pin only while switching is enabled
            pair_q <= main_config_reg_ten_q[GSP_EXTSW_BIT] & fast_source_select_pin_lvl; // RULE4
            io4_oe_q <= general_io_control_reg_q[GSP_IO4_DIR_BIT]; // RULE6
            io4_out_q <= general_io_control_reg_q[GSP_IO4_VAL_BIT];
            srf_q <= main_status_reg_two_q[GSP_ST_FAIL_BIT]; // RULE7
            srf_oe_q <= main_config_reg_ten_q[GSP_SRF_EN_BIT]; // RULE8
            // disabled lock pin is driven low, never floated
            lock_q <= main_config_reg_one_q & dpll_locked; // RULE9 RULE10
        end
    end

    // asserted level of the shared pin in interrupt mode
    always_comb begin
        if (irq_config_reg_q[GSP_GPO_BIT]) begin
            intr_val = irq_config_reg_q[GSP_GPO_VAL_BIT];
        end else if (irq_config_reg_q[GSP_ACT_HIGH_BIT]) begin
            intr_val = irq_q;
        end else begin
            intr_val = ~irq_q;
        end
    end

    // shared pin; loss mode is unlatched and always push-pull
    always_ff @(posedge core_clk or posedge rst_int) begin
        if (rst_int) begin
            intr_q <= 1'b0;
            intr_oe_q <= 1'b0;
        end else if (irq_config_reg_q[GSP_LOS_MODE_BIT]) begin
            intr_q <= los_now; // RULE13
            intr_oe_q <= 1'b1;
        end else if (irq_config_reg_q[GSP_OPEN_DRAIN_BIT]) begin
            intr_q <= 1'b0; // RULE12
            intr_oe_q <= ~intr_val;
        end else begin
            intr_q <= intr_val; // RULE12
            intr_oe_q <= 1'b1;
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign general_io_pin4_out = io4_out_q;
    assign general_io_pin4_oe = io4_oe_q;
    assign ref_fail_output = srf_q;
    assign ref_fail_output_oe = srf_oe_q;
    assign lock_pin_out = lock_q;
    assign irq_request_out = intr_q;
    assign irq_request_out_oe = intr_oe_q;
    assign pair_select = pair_q;
    assign rate_family_bit = rate_cfg_q[GSP_RATE_FAM_BIT];
    assign digital_out1_rate_sel = rate_cfg_q[GSP_DIG1_BIT];
    assign digital_out2_rate_sel = rate_cfg_q[GSP_DIG2_BIT];
    assign irq = irq_q;

    // checks, all on the core clock
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst_int);

    // a request first waits, then is answered
    sequence s_req_waiting;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_answered;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    a_bus_answer_time: assert property (s_req_waiting |=> s_answered)
        else $error("bus answer not after one wait cycle");
    a_reset_holds_all: assert property ( // RULE1
        disable iff (1'b0) rst |=> !strap_done_q && avs_waitrequest && !irq)
        else $error("block not held in reset");
    a_release_synced: assert property ( // RULE14
        disable iff (1'b0) $fell(rst_int) |-> !rst && !$past(rst))
        else $error("internal reset released too early");
    a_switch_strap_take: assert property ( // RULE3
        $rose(strap_done_q) |->
        main_config_reg_ten_q[GSP_EXTSW_BIT] == $past(fast_source_select_pin_lvl))
        else $error("switch strap not captured");
    a_rate_strap_take: assert property ( // RULE5
        $rose(strap_done_q) |-> rate_cfg_q == {3{$past(io4_lvl)}})
        else $error("rate strap not captured");
    a_pair_select_gate: assert property ( // RULE4
        strap_done_q |=> pair_select ==
        ($past(main_config_reg_ten_q[GSP_EXTSW_BIT]) && $past(fast_source_select_pin_lvl)))
        else $error("pair select wrong");
    a_io4_drive_dir: assert property ( // RULE6
        general_io_control_reg_q[GSP_IO4_DIR_BIT] |=> general_io_pin4_oe
        && general_io_pin4_out == $past(general_io_control_reg_q[GSP_IO4_VAL_BIT]))
        else $error("io4 not driven as set");
    a_fail_pin_follow: assert property ( // RULE7
        main_config_reg_ten_q[GSP_SRF_EN_BIT] |=> ref_fail_output_oe
        && ref_fail_output == $past(main_status_reg_two_q[GSP_ST_FAIL_BIT]))
        else $error("fail pin not following latch");
    a_fail_pin_float: assert property ( // RULE8
        !main_config_reg_ten_q[GSP_SRF_EN_BIT] |=> !ref_fail_output_oe)
        else $error("fail pin driven while disabled");
    a_lock_pin_show: assert property ( // RULE9
        main_config_reg_one_q |=> lock_pin_out == $past(dpll_locked))
        else $error("lock pin not showing lock");
    a_lock_pin_low: assert property ( // RULE10
        !main_config_reg_one_q |=> !lock_pin_out)
        else $error("lock pin not low while disabled");
    a_mode_default_irq: assert property ( // RULE11
        $rose(strap_done_q) |-> !irq_config_reg_q[GSP_LOS_MODE_BIT])
        else $error("shared pin mode not interrupt after reset");
    a_irq_polarity_drive: assert property ( // RULE12
        irq_config_reg_q[2:0] == 3'h2 && !irq_config_reg_q[GSP_GPO_BIT]
        |=> irq_request_out_oe && irq_request_out == $past(irq))
        else $error("active high push-pull interrupt wrong");
    a_los_live_value: assert property ( // RULE13
        irq_config_reg_q[GSP_LOS_MODE_BIT] |=> irq_request_out_oe
        && irq_request_out == !$past(sel_ref_active))
        else $error("loss pin not live");
endmodule
`default_nettype wire

// ===== hw/gsp_pkg.sv
// shared constants of the global strap and status pin block
package gsp_pkg;
    // register byte offsets
    localparam logic [5:0] GSP_CFG1_OFS = 6'h00;
    localparam logic [5:0] GSP_RATE_OFS = 6'h04;
    localparam logic [5:0] GSP_CFG10_OFS = 6'h08;
    localparam logic [5:0] GSP_IRQCFG_OFS = 6'h0c;
    localparam logic [5:0] GSP_STS2_OFS = 6'h10;
    localparam logic [5:0] GSP_MASK_OFS = 6'h14;
    localparam logic [5:0] GSP_IOCTL_OFS = 6'h18;
    localparam logic [5:0] GSP_IOSTS_OFS = 6'h1c;
    localparam logic [5:0] GSP_LIVE_OFS = 6'h20;
    // field positions
    localparam int GSP_LOCK_EN_BIT = 0;
    localparam int GSP_RATE_FAM_BIT = 0;
    localparam int GSP_DIG1_BIT = 1;
    localparam int GSP_DIG2_BIT = 2;
    localparam int GSP_EXTSW_BIT = 0;
    localparam int GSP_SRF_EN_BIT = 1;
    localparam int GSP_LOS_MODE_BIT = 0;
    localparam int GSP_ACT_HIGH_BIT = 1;
    localparam int GSP_OPEN_DRAIN_BIT = 2;
    localparam int GSP_GPO_BIT = 3;
    localparam int GSP_GPO_VAL_BIT = 4;
    localparam int GSP_ST_FAIL_BIT = 0;
    localparam int GSP_ST_LOCK_BIT = 1;
    localparam int GSP_ST_LOS_BIT = 2;
    localparam int GSP_ST_IO4_BIT = 3;
    localparam int GSP_IO4_DIR_BIT = 0;
    localparam int GSP_IO4_VAL_BIT = 1;
    localparam int GSP_LV_PAIR_BIT = 0;
    localparam int GSP_LV_LOCK_BIT = 1;
    localparam int GSP_LV_LOS_BIT = 2;
    localparam int GSP_LV_FAIL_BIT = 3;
    // reset values
    localparam logic GSP_CFG1_RST = 1'b0;
    localparam logic [1:0] GSP_CFG10_RST = 2'h0;
    localparam logic [4:0] GSP_IRQCFG_RST = 5'h00;
    localparam logic [3:0] GSP_STS_RST = 4'h0;
    localparam logic [3:0] GSP_MASK_RST = 4'h0;
    localparam logic [1:0] GSP_IOCTL_RST = 2'h0;
    localparam logic [2:0] GSP_RATE_RST = 3'h0;
    // timing counts
    localparam int GSP_RST_HOLD_CYC = 2;
    localparam int GSP_RST_STAGES = 2;
endpackage

// ===== hw/gsp_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module gsp_sync3 (
    // clock
    input wire logic core_clk,
    // raw pin level
    input wire logic pin_in,
    // settled level
    output logic level_out
);
    // no reset: the chain must track the pin through reset
    // so that a strap level is valid at release
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic lvl_q;
    // plain shift chain
    always_ff @(posedge core_clk) begin
        s1_q <= pin_in;
        s2_q <= s1_q;
        s3_q <= s2_q;
    end
    // accept a level once stages two and three agree
    always_ff @(posedge core_clk) begin
        if (s2_q == s3_q) begin
            lvl_q <= s3_q;
        end
    end
    assign level_out = lvl_q;
endmodule
`default_nettype wire

// ===== hw/gsp_rst_sync.sv
// reset synchroniser: asserts at once, releases on the clock
`timescale 1ns/1ps
`default_nettype none
module gsp_rst_sync
    import gsp_pkg::*;
(
    // clock and raw reset
    input wire logic core_clk,
    input wire logic rst,
    // internal reset
    output logic rst_out
);
    logic [GSP_RST_STAGES-1:0] chain_q;
    // ones shift out after release
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            chain_q <= '1;
        end else begin
            chain_q <= {chain_q[GSP_RST_STAGES-2:0], 1'b0};
        end
    end
    assign rst_out = chain_q[GSP_RST_STAGES-1];
endmodule
`default_nettype wire

// ===== verification/gsp_board_model.sv
// board side model: resolves the shared pins with the board pulls
`timescale 1ns/1ps
`default_nettype none
module gsp_board_model (
    // device pin drivers
    input wire logic io4_out,
    input wire logic io4_oe,
    input wire logic irq_out,
    input wire logic irq_oe,
    // board drive of io4
    input wire logic brd_en,
    input wire logic brd_val,
    // resolved wire levels
    output logic io4_wire,
    output logic irq_wire
);
    // pull-down wins only when nobody drives io4
    assign io4_wire = io4_oe ? io4_out : (brd_en ? brd_val : 1'b0);
    // board pull-up so a released open-drain pin reads high
    assign irq_wire = irq_oe ? irq_out : 1'b1;
endmodule
`default_nettype wire

// ===== verification/gsp_top_test.sv
// self-checking bench for the strap and status pin block
`timescale 1ns/1ps
`default_nettype none
module gsp_top_test;
    import gsp_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest;
    logic [3:0] be = 4'hf; // byte lanes of the bus
    logic src_pin = 1'b0;
    logic brd_en = 1'b1; // board holds the strap level during reset
    logic brd_val = 1'b0;
    logic ref_fail_in = 1'b0;
    logic dpll_locked = 1'b0;
    logic sel_ref_active = 1'b1;
    logic io4_out, io4_oe, io4_wire, rf_out, rf_oe, lock_out, irq_out, irq_oe, irq_wire;
    logic pair_sel, rate_fam, dig1, dig2, irq, s_strap, r_strap, act;
    logic [4:0] cfg;
    int mismatches = 0;
    int samples_checked = 0;

    // 10 mhz clock
    always #50 core_clk = ~core_clk;

    gsp_top DUT (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(be), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .fast_source_select_pin(src_pin),
        .general_io_pin4_in(io4_wire), .general_io_pin4_out(io4_out),
        .general_io_pin4_oe(io4_oe), .ref_fail_output(rf_out),
        .ref_fail_output_oe(rf_oe), .lock_pin_out(lock_out),
        .irq_request_out(irq_out), .irq_request_out_oe(irq_oe),
        .ref_fail_in(ref_fail_in), .dpll_locked(dpll_locked),
        .sel_ref_active(sel_ref_active), .pair_select(pair_sel),
        .rate_family_bit(rate_fam), .digital_out1_rate_sel(dig1),
        .digital_out2_rate_sel(dig2), .irq(irq));

    gsp_board_model board (.io4_out(io4_out), .io4_oe(io4_oe), .irq_out(irq_out),
        .irq_oe(irq_oe), .brd_en(brd_en), .brd_val(brd_val), .io4_wire(io4_wire),
        .irq_wire(irq_wire));

    // expected level of the shared interrupt wire under the board pull-up
    function automatic logic exp_irq_pin(input logic [4:0] c, input logic req,
        input logic a);
        if (c[GSP_LOS_MODE_BIT]) return !a;
        if (c[GSP_GPO_BIT]) return c[GSP_GPO_VAL_BIT];
        return c[GSP_ACT_HIGH_BIT] ? req : !req;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // one bus cycle, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] wd);
        int n;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= w;
        avs_read <= !w;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            mismatches++;
            $display("[ERR] %0t bus answer timed out", $time);
            tally_and_finish();
        end
    endtask

    task automatic rdchk(input logic [5:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, a, 32'h0);
        chk(rd, exp, what);
    endtask

    // pins pass a synchroniser and a few register stages
    task automatic settle;
        repeat (8) @(posedge core_clk);
    endtask

    // reset with fresh random straps
    task automatic do_reset;
        @(posedge core_clk);
        rst <= 1'b1;
        s_strap = 1'($urandom_range(1, 0));
        r_strap = 1'($urandom_range(1, 0));
        src_pin <= s_strap;
        brd_en <= 1'b1;
        brd_val <= r_strap;
        repeat (3) @(posedge core_clk);
        chk(avs_waitrequest, 1, "wait in reset");
        chk({irq, lock_out, rf_oe, irq_oe, io4_oe}, 0, "outputs in reset");
        repeat (9) @(posedge core_clk);
        rst <= 1'b0;
        repeat (6) @(posedge core_clk);
        brd_en <= 1'b0;
        chk({rate_fam, dig1, dig2}, {3{r_strap}}, "rate defaults");
        rdchk(GSP_CFG10_OFS, {31'h0, s_strap}, "switch strap");
    endtask

    // watchdog on the whole run
    initial begin
        repeat (30000) @(posedge core_clk);
        mismatches++;
        $display("[ERR] %0t run timed out", $time);
        tally_and_finish();
    end

    initial begin
        rd = $urandom(78554);
        // each pass re-runs everything after a mid-run reset
        for (int it = 0; it < 3; it++) begin
            do_reset();
            rdchk(6'h3c, 32'h0, "unmapped read");
            dpll_locked <= 1'b1;
            settle();
            chk(lock_out, 0, "lock disabled low");
            bus(1'b1, GSP_CFG1_OFS, 32'h1);
            for (int v = 0; v < 2; v++) begin
                dpll_locked <= v[0];
                settle();
                chk(lock_out, v[0], "lock follows");
            end
            be <= 4'he; // lane zero off: the write must be ignored
            bus(1'b1, GSP_CFG1_OFS, 32'h0);
            be <= 4'hf;
            rdchk(GSP_CFG1_OFS, 32'h1, "lane zero off ignored");
            // fail event with pin disabled, then enabled
            bus(1'b1, GSP_MASK_OFS, 32'h1);
            ref_fail_in <= 1'b1;
            settle();
            chk(rf_oe, 0, "fail pin floats");
            chk({irq, irq_wire}, 2'b10, "irq active low");
            ref_fail_in <= 1'b0;
            bus(1'b1, GSP_CFG10_OFS, 32'h2);
            settle();
            chk({rf_oe, rf_out}, 2'b11, "fail latched");
            bus(1'b1, GSP_STS2_OFS, 32'h1);
            settle();
            chk({rf_out, irq}, 0, "fail cleared");
            // shared pin modes, random options, request off then on
            for (int k = 0; k < 8; k++) begin
                if (k == 4) ref_fail_in <= 1'b1;
                act = 1'($urandom_range(1, 0));
                sel_ref_active <= act;
                cfg = {4'($urandom_range(15, 0)), k[0]};
                bus(1'b1, GSP_IRQCFG_OFS, {27'h0, cfg});
                settle();
                chk(irq_wire, exp_irq_pin(cfg, k >= 4, act), "shared pin");
                if (cfg[GSP_OPEN_DRAIN_BIT] && !cfg[0] && !cfg[GSP_GPO_BIT])
                    chk(irq_out, 0, "open drain low only");
            end
            // corner: active high, push-pull, request still pending
            bus(1'b1, GSP_IRQCFG_OFS, 32'h2);
            settle();
            chk({irq_oe, irq_out}, 2'b11, "active high push-pull");
            ref_fail_in <= 1'b0;
            bus(1'b1, GSP_IRQCFG_OFS, 32'h0);
            bus(1'b1, GSP_STS2_OFS, 32'hf);
            // io4 as output, then as input with the board driving
            bus(1'b1, GSP_IOCTL_OFS, 32'h3);
            settle();
            chk({io4_oe, io4_wire}, 2'b11, "io4 drives");
            rdchk(GSP_IOSTS_OFS, 32'h1, "io4 status out");
            bus(1'b1, GSP_IOCTL_OFS, 32'h0);
            for (int v = 0; v < 2; v++) begin
                brd_en <= 1'b1;
                brd_val <= !v[0];
                settle();
                chk(io4_oe, 0, "io4 input");
                rdchk(GSP_IOSTS_OFS, {31'h0, !v[0]}, "io4 status in");
            end
            brd_en <= 1'b0;
            // pin-driven pair choice once enabled
            bus(1'b1, GSP_CFG10_OFS, 32'h1);
            for (int v = 0; v < 2; v++) begin
                src_pin <= !v[0];
                settle();
                chk(pair_sel, !v[0], "pair select");
            end
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
